// *** design/sbt_map.svh ***
`ifndef SBT_MAP_SVH
`define SBT_MAP_SVH

// register offsets on the plain register port
`define SBT_OFS_FLAG     8'h0c
`define SBT_OFS_CLEAR    8'h0d
`define SBT_OFS_LOW      8'h0e
`define SBT_OFS_HIGH     8'h0f
`define SBT_OFS_CONTROL  8'h10
`define SBT_OFS_ENABLE   8'h8c

// control field positions
`define SBT_RUN_BIT      0
`define SBT_SRC_BIT      1
`define SBT_SYNC_DIS_BIT 2
`define SBT_OSC_EN_BIT   3
`define SBT_PRE_LSB      4
`define SBT_PRE_MSB      5
`define SBT_CTRL_W       6

// flag and enable layout
`define SBT_OVF_BIT      0

// reset values and limits
`define SBT_CTRL_RST     6'h00
`define SBT_COUNT_RST    16'h0000
`define SBT_COUNT_MAX    16'hffff
`define SBT_PRE_W        3

`endif

// *** design/sbt_pkg.sv ***
package sbt_pkg;
  `include "sbt_map.svh"

  typedef logic [7:0] sbt_addr_t;
  typedef logic [7:0] sbt_byte_t;

  // how the count register advances
  typedef enum logic [1:0] {
    SBT_STOP  = 2'b00,
    SBT_TIMER = 2'b01,
    SBT_SYNC  = 2'b10,
    SBT_ASYNC = 2'b11
  } sbt_mode_t;

  typedef struct packed {
    logic [`SBT_CTRL_W-1:0] control;
    logic [15:0]            count;
    logic                   flag;
    logic                   enable;
    logic [7:0]             rd_data;
    logic [2:0]             sync;
    logic                   irq;
    logic                   osc_out;
    logic [1:0]             dir_eff;
  } sbt_state_t;

  typedef struct packed {
    logic [`SBT_PRE_W-1:0] cnt;
  } sbt_pre_state_t;
endpackage : sbt_pkg

// *** design/sbt_prescale.sv ***
`timescale 1ns/1ns
// divides the count clock ticks by 1, 2, 4 or 8
module sbt_prescale (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       tick_in,
  input  wire logic [1:0] ratio,
  input  wire logic       clear,
  output logic            tick_out
);
  import sbt_pkg::*;

  sbt_pre_state_t s;
  sbt_pre_state_t next_s;

  // mask of low counter bits that must be all ones for a tick
  function automatic logic [`SBT_PRE_W-1:0] ratio_mask(input logic [1:0] r);
    case (r)
      2'b00:   ratio_mask = 3'h0;
      2'b01:   ratio_mask = 3'h1;
      2'b10:   ratio_mask = 3'h3;
      default: ratio_mask = 3'h7;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // pass a tick when the masked counter is full
  always_comb begin
    next_s   = s;
    tick_out = tick_in && ((s.cnt & ratio_mask(ratio)) == ratio_mask(ratio));
    if (clear) begin
      next_s.cnt = 3'h0; // a count write restarts the division
    end else if (tick_in) begin
      next_s.cnt = s.cnt + 3'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_pass_through;
    ratio == 2'b00 && tick_in |-> tick_out;
  endproperty
  a_pass_through: assert property (p_pass_through)
    else $error("undivided ratio dropped a tick");

  property p_div_eight;
    ratio == 2'b11 && tick_out |-> s.cnt == 3'h7 && tick_in;
  endproperty
  a_div_eight: assert property (p_div_eight)
    else $error("1:8 tick out of phase");

  property p_div_two;
    ratio == 2'b01 && !clear && tick_out |=> !tick_out;
  endproperty
  a_div_two: assert property (p_div_two)
    else $error("1:2 ticked twice in a row");

  c_div_four: cover property (ratio == 2'b10 && tick_out);
endmodule // sbt_prescale

// *** design/sbt_timer.sv ***
`timescale 1ns/1ns
module sbt_timer (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire sbt_pkg::sbt_addr_t bus_addr,
  input  wire sbt_pkg::sbt_byte_t bus_wdata,
  input  wire logic              bus_write,
  input  wire logic              bus_read,
  output sbt_pkg::sbt_byte_t     bus_rdata,
  input  wire logic              sleep_mode,
  input  wire logic              ext_count_clock_pin,
  input  wire logic              osc_input_pin,
  output logic                   osc_output_pin,
  output logic                   osc_amp_enable,
  input  wire logic [1:0]        port_c_direction,
  output logic [1:0]             port_c_dir_eff,
  output logic                   overflow_irq
);
  import sbt_pkg::*;

  sbt_state_t s;
  sbt_state_t next_s;
  sbt_mode_t  mode;
  logic       ext_level;
  logic       ext_rise;
  logic       raw_tick;
  logic       tick;
  logic       wr_low;
  logic       wr_high;
  logic       count_wr;
  logic       wr_ctrl;
  logic       wrap;
  logic       flag_clr;

  // control bits to counting mode; the sync bit matters only externally
  function automatic sbt_mode_t count_mode(input logic [`SBT_CTRL_W-1:0] c);
    if (!c[`SBT_RUN_BIT]) begin
      count_mode = SBT_STOP;
    end else if (!c[`SBT_SRC_BIT]) begin
      count_mode = SBT_TIMER;
    end else if (c[`SBT_SYNC_DIS_BIT]) begin
      count_mode = SBT_ASYNC;
    end else begin
      count_mode = SBT_SYNC;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // write decode
  assign wr_low   = bus_write && bus_addr == `SBT_OFS_LOW;
  assign wr_high  = bus_write && bus_addr == `SBT_OFS_HIGH;
  assign wr_ctrl  = bus_write && bus_addr == `SBT_OFS_CONTROL;
  assign count_wr = wr_low || wr_high;
  assign flag_clr = bus_write && bus_addr == `SBT_OFS_CLEAR && bus_wdata[`SBT_OVF_BIT];

  // with the oscillator on, the crystal drives the count input
  assign ext_level = s.control[`SBT_OSC_EN_BIT] ? osc_input_pin
                                                : ext_count_clock_pin;
  assign ext_rise  = s.sync[1] && !s.sync[2];

  // the internal clock stops in sleep, so only async counting survives
  always_comb begin
    mode = count_mode(s.control);
    case (mode)
      SBT_TIMER: raw_tick = !sleep_mode;
      SBT_SYNC:  raw_tick = ext_rise && !sleep_mode;
      SBT_ASYNC: raw_tick = ext_rise;
      default:   raw_tick = 1'b0;
    endcase
  end

  sbt_prescale u_prescale (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .tick_in  (raw_tick),
    .ratio    (s.control[`SBT_PRE_MSB:`SBT_PRE_LSB]),
    .clear    (count_wr),
    .tick_out (tick)
  );

  // a byte write takes precedence over a tick in the same cycle
  assign wrap = tick && !count_wr && s.count == `SBT_COUNT_MAX;

  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_s      = s;
    next_s.sync = {s.sync[1:0], ext_level}; // plain three-stage chain
    // count register pair
    if (wr_low) begin
      next_s.count[7:0] = bus_wdata;
    end else if (wr_high) begin
      next_s.count[15:8] = bus_wdata;
    end else if (tick) begin
      next_s.count = s.count + 16'h0001;
    end
    if (wr_ctrl) begin
      next_s.control = bus_wdata[`SBT_CTRL_W-1:0];
    end
    if (bus_write && bus_addr == `SBT_OFS_ENABLE) begin
      next_s.enable = bus_wdata[`SBT_OVF_BIT];
    end
    // set wins over a clear in the same cycle
    if (flag_clr) begin
      next_s.flag = 1'b0;
    end
    if (wrap) begin
      next_s.flag = 1'b1;
    end
    next_s.irq = next_s.flag && next_s.enable;
    // crystal amplifier: inverter from input pin, silent when disabled
    next_s.osc_out = s.control[`SBT_OSC_EN_BIT] && !osc_input_pin;
    next_s.dir_eff = s.control[`SBT_OSC_EN_BIT] ? 2'b11 : port_c_direction;
    // read data, one cycle after the strobe; unmapped reads zero
    next_s.rd_data = 8'h00;
    if (bus_read) begin
      case (bus_addr)
        `SBT_OFS_FLAG:    next_s.rd_data = {7'h00, s.flag};
        `SBT_OFS_ENABLE:  next_s.rd_data = {7'h00, s.enable};
        `SBT_OFS_LOW:     next_s.rd_data = s.count[7:0];
        `SBT_OFS_HIGH:    next_s.rd_data = s.count[15:8];
        `SBT_OFS_CONTROL: next_s.rd_data = {2'b00, s.control};
        default:          next_s.rd_data = 8'h00;
      endcase
    end
  end

  // the oscillator enable has no start-up timer here; software waits
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops
  assign bus_rdata      = s.rd_data;
  assign osc_output_pin = s.osc_out;
  assign osc_amp_enable = s.control[`SBT_OSC_EN_BIT];
  assign port_c_dir_eff = s.dir_eff;
  assign overflow_irq   = s.irq;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_ctrl_top_zero;
    bus_read && bus_addr == `SBT_OFS_CONTROL |=> bus_rdata[7:6] == 2'b00;
  endproperty
  a_ctrl_top_zero: assert property (p_ctrl_top_zero)
    else $error("control bits 7:6 read nonzero");

  property p_wrap_zero;
    tick && !count_wr && s.count == 16'hffff |=> s.count == 16'h0000;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero)
    else $error("count did not wrap to zero");

  property p_wrap_flag;
    wrap || (s.flag && !flag_clr) |=> s.flag;
  endproperty
  a_wrap_flag: assert property (p_wrap_flag)
    else $error("overflow flag not latched");

  property p_irq_gate;
    overflow_irq == (s.flag && s.enable);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt not gated by enable");

  property p_hold;
    !s.control[`SBT_RUN_BIT] && !count_wr |=> $stable(s.count);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stopped timer changed count");

  property p_timer_step;
    mode == SBT_TIMER && !sleep_mode && !count_wr
      && s.control[`SBT_PRE_MSB:`SBT_PRE_LSB] == 2'b00
      |=> s.count == $past(s.count) + 16'h0001;
  endproperty
  a_timer_step: assert property (p_timer_step)
    else $error("timer mode missed a cycle");

  property p_sync_sleep;
    mode == SBT_SYNC && sleep_mode && !count_wr |=> $stable(s.count);
  endproperty
  a_sync_sleep: assert property (p_sync_sleep)
    else $error("synchronised counter ran in sleep");

  property p_pins_input;
    s.control[`SBT_OSC_EN_BIT] |=> port_c_dir_eff == 2'b11;
  endproperty
  a_pins_input: assert property (p_pins_input)
    else $error("oscillator pins not forced input");

  property p_osc_off;
    !s.control[`SBT_OSC_EN_BIT] |=> !osc_output_pin;
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("disabled oscillator still driving");

  property p_osc_sleep;
    s.control[`SBT_OSC_EN_BIT] && sleep_mode |=> osc_output_pin == !$past(osc_input_pin);
  endproperty
  a_osc_sleep: assert property (p_osc_sleep)
    else $error("oscillator stopped in sleep");

  c_wrap:       cover property (wrap);
  c_async_tick: cover property (mode == SBT_ASYNC && sleep_mode && tick);
  c_irq:        cover property ($rose(overflow_irq));
  c_byte_write: cover property (wr_low ##2 wr_high);
endmodule // sbt_timer

// *** verification/sbt_clk_src.sv ***
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// far-side count clock or crystal: low and still while idle
module sbt_clk_src #(
  parameter int HALF = 4
) (
  input  wire logic clk_sys,
  input  wire logic run,
  output logic      pin
);
  int cnt;

  // slow toggle so the three-flop synchroniser sees every edge
  always_ff @(posedge clk_sys) begin
    if (!run) begin
      cnt <= 0;
      pin <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      pin <= ~pin;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // sbt_clk_src

// *** verification/sbt_timer_tb.sv ***
`timescale 1ns/1ns
`include "sbt_map.svh"
module sbt_timer_tb;
  import sbt_pkg::*;
  logic       clk_sys = 1'b0;
  logic       sys_rst = 1'b1;
  sbt_addr_t  bus_addr = 8'h00;
  sbt_byte_t  bus_wdata = 8'h00;
  logic       bus_write = 1'b0;
  logic       bus_read = 1'b0;
  sbt_byte_t  bus_rdata;
  logic       sleep_mode = 1'b0;
  logic       src_run = 1'b0;
  logic       src_pin;
  logic       osc_output_pin;
  logic       osc_amp_enable;
  logic [1:0] port_c_direction = 2'h0;
  logic [1:0] port_c_dir_eff;
  logic       overflow_irq;
  int         miscompares = 0;
  int         comparisons = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // one source feeds both count inputs; the control register picks one
  sbt_clk_src src (.clk_sys(clk_sys), .run(src_run), .pin(src_pin));
  sbt_timer uut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
    .sleep_mode(sleep_mode), .ext_count_clock_pin(src_pin), .osc_input_pin(src_pin),
    .osc_output_pin(osc_output_pin), .osc_amp_enable(osc_amp_enable),
    .port_c_direction(port_c_direction), .port_c_dir_eff(port_c_dir_eff),
    .overflow_irq(overflow_irq));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input sbt_addr_t a, input sbt_byte_t d);
    @(posedge clk_sys);
    bus_write <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_write <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input sbt_addr_t a, output sbt_byte_t d);
    @(posedge clk_sys);
    bus_read <= 1'b1;
    bus_addr <= a;
    @(posedge clk_sys);
    bus_read <= 1'b0;
    #1 d = bus_rdata;
  endtask

  task automatic rdchk(input sbt_addr_t a, input sbt_byte_t e);
    sbt_byte_t d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask

  task automatic rdcount(output logic [15:0] c);
    rd(`SBT_OFS_LOW, c[7:0]);
    rd(`SBT_OFS_HIGH, c[15:8]);
  endtask

  task automatic set_count(input logic [15:0] c);
    wr(`SBT_OFS_LOW, c[7:0]);
    wr(`SBT_OFS_HIGH, c[15:8]);
  endtask

  // n rising edges, then room for the three-cycle edge pipeline
  task automatic pulses(input int n);
    src_run <= 1'b1;
    repeat (n * 8) @(posedge clk_sys);
    src_run <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [15:0] c;
    rdchk(`SBT_OFS_CONTROL, 8'h00);
    wr(`SBT_OFS_CONTROL, 8'hfe);
    rdchk(`SBT_OFS_CONTROL, 8'h3e);
    wr(`SBT_OFS_CONTROL, 8'h00);
    set_count(16'h5aa5);
    rdcount(c);
    chk(c, 16'h5aa5);
    rdchk(8'h33, 8'h00);
  endtask

  // 16 raw ticks between run and stop; the table covers every prescale code
  task automatic t_prescale;
    logic [7:0]  ctl [5] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h05};
    logic [15:0] exp [5] = '{16'h10, 16'h08, 16'h04, 16'h02, 16'h10};
    logic [15:0] c;
    logic [15:0] c2;
    for (int i = 0; i < 5; i++) begin
      set_count(16'h0000);
      wr(`SBT_OFS_CONTROL, ctl[i]);
      repeat (14) @(posedge clk_sys);
      wr(`SBT_OFS_CONTROL, 8'h00);
      rdcount(c);
      chk(c, exp[i]);
    end
    repeat (10) @(posedge clk_sys);
    rdcount(c2);
    chk(c2, c);
  endtask

  task automatic t_wrap;
    logic [15:0] c;
    set_count(16'hffff);
    wr(`SBT_OFS_ENABLE, 8'h01);
    wr(`SBT_OFS_CONTROL, 8'h01);
    wr(`SBT_OFS_CONTROL, 8'h00);
    rdcount(c);
    // ticks land at the two edges while run stands: ffff, then 0000, then 0001
    chk(c, 16'h0001);
    rdchk(`SBT_OFS_FLAG, 8'h01);
    chk({15'h0, overflow_irq}, 16'h1);
    wr(`SBT_OFS_ENABLE, 8'h00);
    @(posedge clk_sys);
    #1 chk({15'h0, overflow_irq}, 16'h0);
    rdchk(`SBT_OFS_FLAG, 8'h01);
    wr(`SBT_OFS_ENABLE, 8'h01);
    wr(`SBT_OFS_CLEAR, 8'h01);
    @(posedge clk_sys);
    #1 chk({15'h0, overflow_irq}, 16'h0);
    rdchk(`SBT_OFS_FLAG, 8'h00);
  endtask

  task automatic t_osc;
    logic [15:0] c;
    set_count(16'h0000);
    wr(`SBT_OFS_CONTROL, 8'h0b);
    // the effective direction follows the control bit one cycle late
    @(posedge clk_sys);
    #1 chk({15'h0, osc_amp_enable}, 16'h1);
    chk({14'h0, port_c_dir_eff}, 16'h3);
    // no hardware start-up timer, so software waits before relying on it
    repeat (20) @(posedge clk_sys);
    src_run <= 1'b1;
    repeat (6) @(posedge clk_sys);
    #1 chk({15'h0, osc_output_pin}, {15'h0, ~src_pin});
    repeat (26) @(posedge clk_sys);
    src_run <= 1'b0;
    repeat (6) @(posedge clk_sys);
    port_c_direction <= 2'h1;
    wr(`SBT_OFS_CONTROL, 8'h00);
    rdcount(c);
    chk(c, 16'h0004);
    chk({15'h0, osc_amp_enable}, 16'h0);
    chk({14'h0, port_c_dir_eff}, 16'h1);
  endtask

  // in sleep only the asynchronous path keeps counting
  task automatic t_sleep;
    logic [15:0] c;
    set_count(16'h0000);
    sleep_mode <= 1'b1;
    wr(`SBT_OFS_CONTROL, 8'h03);
    pulses(4);
    wr(`SBT_OFS_CONTROL, 8'h0f);
    repeat (20) @(posedge clk_sys);
    pulses(4);
    wr(`SBT_OFS_CONTROL, 8'h00);
    sleep_mode <= 1'b0;
    rdcount(c);
    chk(c, 16'h0004);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_prescale();
    t_wrap();
    t_osc();
    t_sleep();
    tally_and_finish();
  end

  // the sequence needs well under 2000 cycles
  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end
endmodule // sbt_timer_tb
